//--- rtl/cnc_defs.svh
// Purpose: Constants for the clock network control block
// Assumes: 32-bit APB data, one word per register
// Notes: Byte address is four times the register index
`ifndef CNC_DEFS_SVH
`define CNC_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define CNC_NGLB 16
`define CNC_NRGN 32
`define CNC_NRPQ 8
`define CNC_NQ 4
`define CNC_NLPO 4
`define CNC_NPIN 12
`define CNC_NLOOP 8
`define CNC_NCORE 4
`define CNC_NXCVR 2
`define CNC_NROW 6
`define CNC_NLAB 3
`define CNC_SELW 5
`define CNC_LABW 3
`define CNC_NCFG 64

// ****************************************
// Register indexes
// ****************************************
`define CNC_IDX_GLB 0
`define CNC_IDX_RGN 16
`define CNC_IDX_LPO 48
`define CNC_IDX_QROW 52
`define CNC_IDX_QIOE 56
`define CNC_IDX_QLAB 60
`define CNC_IDX_STG 64
`define CNC_IDX_STR 65
`define CNC_IDX_NUM 66

// ****************************************
// Fields
// ****************************************
`define CNC_F_SEL 0
`define CNC_F_DYN 5
`define CNC_F_CA 6
`define CNC_F_CB 11
`define CNC_F_ON 16
`define CNC_F_PMUX 17
`define CNC_F_DUAL 18
`define CNC_F_VERT 19
`define CNC_F_COLIOE 0
`define CNC_F_ROWIOE 5

// ****************************************
// Source masks
// ****************************************
`define CNC_M_GLB 32'h03FFFFFF
`define CNC_M_RGN 32'h03FFFFF0
`define CNC_M_HORZ 32'h00F30FF0
`define CNC_M_VERT 32'h00F0F00F
`define CNC_M_BUS 32'h00FFFFFF
`define CNC_M_ROW 32'h0000003F

`define CNC_ADDR_HI 32'h00000000
`define CNC_RST_WORD 32'h00000000

`endif

//--- rtl/cnc_pkg.sv
// Purpose: Types for the clock network control block
// Assumes: cnc_defs.svh supplies all sizes
// Notes: Whole module state is one packed struct
`include "cnc_defs.svh"

package cnc_pkg;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [`CNC_NCFG-1:0][31:0] cfg;
    logic [`CNC_NGLB-1:0] gen;
    logic [`CNC_NRGN-1:0] ren;
    logic [`CNC_NLPO-1:0] len;
    logic [`CNC_NGLB-1:0] glb;
    logic [`CNC_NRGN-1:0] rgn;
    logic [`CNC_NLPO-1:0] lpo;
    logic [`CNC_NQ*`CNC_NLAB-1:0] logic_array_block;
    logic [`CNC_NQ-1:0] col;
    logic [`CNC_NQ-1:0] row;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cnc_state_t;

endpackage

//--- rtl/cnc_clock_network_control.sv
// Purpose: Clock source selection, gating and distribution
// Assumes: Clock levels are sampled on CLOCK
// Notes: Configuration is written over APB before user mode
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cnc_defs.svh"

module cnc_clock_network_control (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic USER_MODE,
  input wire logic [`CNC_NPIN-1:0] CLK_PIN,
  input wire logic [`CNC_NLOOP-1:0] LOOP_OUT,
  input wire logic [`CNC_NCORE-1:0] CORE_CLK,
  input wire logic [`CNC_NXCVR-1:0] XCVR_CLK,
  input wire logic [`CNC_NGLB-1:0] DYN_SEL,
  input wire logic [`CNC_NGLB-1:0] GLB_ENA,
  input wire logic [`CNC_NRGN-1:0] RGN_ENA,
  input wire logic [`CNC_NLPO-1:0] LPO_ENA,
  input wire logic [`CNC_NLPO-1:0] LPO_INT,
  output logic [`CNC_NGLB-1:0] GLOBAL_CLOCK_NET,
  output logic [`CNC_NRGN-1:0] REGIONAL_CLOCK_NET,
  output logic [`CNC_NLPO-1:0] LOOP_PIN,
  output logic [`CNC_NQ*`CNC_NLAB-1:0] LAB_CLOCK,
  output logic [`CNC_NQ-1:0] COL_IOE_CLOCK,
  output logic [`CNC_NQ-1:0] ROW_IOE_CLOCK
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic pick(
    input logic [31:0] v,
    input logic [4:0] s,
    input logic [31:0] m
  );
    pick = v[s] & m[s];
  endfunction

  // ****************************************
  // State
  // ****************************************
  cnc_pkg::cnc_state_t s_r;
  cnc_pkg::cnc_state_t s_nxt;

  logic [31:0] src;
  logic [6:0] idx;
  logic mapped;

  assign src = {6'h00, XCVR_CLK, CORE_CLK, LOOP_OUT, CLK_PIN};
  assign idx = PADDR[8:2];
  assign mapped = (PADDR[11:9] == 3'h0) && (idx < 7'(`CNC_IDX_NUM));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] w;
    logic [31:0] wb;
    logic [31:0] msk;
    logic [31:0] bus;
    logic [`CNC_SELW-1:0] sel;
    logic [`CNC_NROW-1:0] rc;
    logic [1:0] bq;
    logic lv;
    logic ccb;
    w = 32'h0;
    wb = 32'h0;
    msk = 32'h0;
    bus = 32'h0;
    sel = '0;
    rc = '0;
    bq = 2'h0;
    lv = 1'b0;
    ccb = 1'b0;
    s_nxt = s_r;

    // Global nets
    for (int i = 0; i < `CNC_NGLB; i++) begin
      w = s_r.cfg[`CNC_IDX_GLB + i];
      if (w[`CNC_F_DYN] && USER_MODE) begin
        if (DYN_SEL[i]) begin
          sel = w[`CNC_F_CB +: `CNC_SELW];
        end else begin
          sel = w[`CNC_F_CA +: `CNC_SELW];
        end
      end else begin
        sel = w[`CNC_F_SEL +: `CNC_SELW];
      end
      lv = pick(src, sel, `CNC_M_GLB);
      if (!lv) begin
        s_nxt.gen[i] = GLB_ENA[i] & w[`CNC_F_ON];
      end
      s_nxt.glb[i] = lv & s_nxt.gen[i];
    end

    // Regional nets
    for (int q = 0; q < `CNC_NQ; q++) begin
      for (int k = 0; k < `CNC_NRPQ; k++) begin
        w = s_r.cfg[`CNC_IDX_RGN + q * `CNC_NRPQ + k];
        msk = `CNC_M_RGN;
        wb = w;
        if (w[`CNC_F_DUAL]) begin
          if (w[`CNC_F_VERT]) begin
            bq = 2'(q) & 2'h1;
            msk = `CNC_M_VERT;
          end else begin
            bq = 2'(q) & 2'h2;
            msk = `CNC_M_HORZ;
          end
          wb = s_r.cfg[`CNC_IDX_RGN + 32'(bq) * `CNC_NRPQ + k];
        end
        sel = wb[`CNC_F_SEL +: `CNC_SELW];
        lv = pick(src, sel, msk);
        if (!lv) begin
          s_nxt.ren[q * `CNC_NRPQ + k] =
            RGN_ENA[q * `CNC_NRPQ + k] & w[`CNC_F_ON];
        end
        s_nxt.rgn[q * `CNC_NRPQ + k] = lv & s_nxt.ren[q * `CNC_NRPQ + k];
      end
    end

    // Loop clock output pins
    for (int j = 0; j < `CNC_NLPO; j++) begin
      w = s_r.cfg[`CNC_IDX_LPO + j];
      sel = w[`CNC_F_SEL +: `CNC_SELW];
      lv = pick(src, sel, `CNC_M_GLB);
      if (!lv) begin
        s_nxt.len[j] = LPO_ENA[j] & w[`CNC_F_ON];
      end
      ccb = lv & s_nxt.len[j];
      if (w[`CNC_F_PMUX]) begin
        s_nxt.lpo[j] = ccb;
      end else begin
        s_nxt.lpo[j] = LPO_INT[j];
      end
    end

    // Quadrant and logic block muxes
    for (int q = 0; q < `CNC_NQ; q++) begin
      bus = {8'h00, s_r.rgn[q * `CNC_NRPQ +: `CNC_NRPQ], s_r.glb};
      w = s_r.cfg[`CNC_IDX_QROW + q];
      for (int m = 0; m < `CNC_NROW; m++) begin
        rc[m] = pick(bus, w[m * `CNC_SELW +: `CNC_SELW], `CNC_M_BUS);
      end
      w = s_r.cfg[`CNC_IDX_QIOE + q];
      s_nxt.col[q] = pick(bus, w[`CNC_F_COLIOE +: `CNC_SELW], `CNC_M_BUS);
      s_nxt.row[q] = pick(bus, w[`CNC_F_ROWIOE +: `CNC_SELW], `CNC_M_BUS);
      w = s_r.cfg[`CNC_IDX_QLAB + q];
      for (int m = 0; m < `CNC_NLAB; m++) begin
        s_nxt.logic_array_block[q * `CNC_NLAB + m] = pick({26'h0, rc},
          {2'h0, w[m * `CNC_LABW +: `CNC_LABW]}, `CNC_M_ROW);
      end
    end

    // APB slave
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0;
    if (PSEL && PENABLE && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      if (!mapped) begin
        s_nxt.pslverr = 1'b1;
      end else if (PWRITE && (USER_MODE || idx >= 7'(`CNC_NCFG))) begin
        s_nxt.pslverr = 1'b1;
      end else if (PWRITE) begin
        s_nxt.pslverr = 1'b0;
      end else if (idx == 7'(`CNC_IDX_STG)) begin
        s_nxt.prdata = {16'h0000, s_r.glb};
      end else if (idx == 7'(`CNC_IDX_STR)) begin
        s_nxt.prdata = s_r.rgn;
      end else begin
        s_nxt.prdata = s_r.cfg[idx[5:0]];
      end
    end
    if (PSEL && PENABLE && s_r.pready && PWRITE && !s_r.pslverr) begin
      s_nxt.cfg[idx[5:0]] = PWDATA;
    end

    if (RST) begin
      s_nxt = '0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK) begin
    s_r <= s_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign GLOBAL_CLOCK_NET = s_r.glb;
  assign REGIONAL_CLOCK_NET = s_r.rgn;
  assign LOOP_PIN = s_r.lpo;
  assign LAB_CLOCK = s_r.logic_array_block;
  assign COL_IOE_CLOCK = s_r.col;
  assign ROW_IOE_CLOCK = s_r.row;

endmodule // cnc_clock_network_control

//--- sim/cnc_checker_sva.sv
// Purpose: Port checker for the clock network control block
// Assumes: APB answer in the second access cycle
// Notes: Bound to the design module below
`timescale 1ns/1ps
`include "cnc_defs.svh"
module cnc_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic USER_MODE,
  input wire logic [`CNC_NGLB-1:0] GLOBAL_CLOCK_NET,
  input wire logic [`CNC_NRGN-1:0] REGIONAL_CLOCK_NET
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic acc;
  assign acc = PSEL && PENABLE && !PREADY;
  AST_TAKE: assert property (acc |=> PREADY && PSEL) else $error("no answer");
  AST_PULSE: assert property (PREADY |=> !PREADY) else $error("long ready");
  AST_IDLE: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stale data");
  AST_OK: assert property (acc && !PWRITE && PADDR < 12'h108 |=> !PSLVERR)
    else $error("read refused");
  AST_UNMAP: assert property (acc && PADDR >= 12'h108 |=> PSLVERR) else $error("unmapped ok");
  AST_RO: assert property (acc && PWRITE && PADDR >= 12'h100 |=> PSLVERR)
    else $error("status written");
  AST_USER: assert property (acc && PWRITE && USER_MODE |=> PSLVERR)
    else $error("user write taken");
  AST_RST: assert property (disable iff (1'b0) RST |=>
    GLOBAL_CLOCK_NET == 16'h0 && REGIONAL_CLOCK_NET == 32'h0) else $error("net live in reset");
endmodule // cnc_checker
bind cnc_clock_network_control cnc_checker u_chk (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .USER_MODE(USER_MODE), .GLOBAL_CLOCK_NET(GLOBAL_CLOCK_NET),
  .REGIONAL_CLOCK_NET(REGIONAL_CLOCK_NET));

//--- sim/cnc_user_model.sv
// Purpose: Array user logic driving selects and enables
// Assumes: Requests come from the bench
// Notes: All outputs change just after a rising edge
`timescale 1ns/1ps
module cnc_user_model (
  input wire logic clock,
  input wire logic [15:0] sel_req,
  input wire logic ena_req,
  output logic [15:0] dyn_sel,
  output logic [15:0] glb_ena,
  output logic [31:0] rgn_ena,
  output logic [3:0] lpo_ena,
  output logic [3:0] core_clk,
  output logic [3:0] lpo_int
);
  initial {dyn_sel, glb_ena, rgn_ena, lpo_ena, core_clk, lpo_int} = 76'h0;
  always @(posedge clock) begin
    dyn_sel <= sel_req;
    glb_ena <= {16{ena_req}};
    rgn_ena <= {32{ena_req}};
    lpo_ena <= {4{ena_req}};
    core_clk <= 4'($urandom);
    lpo_int <= 4'($urandom);
  end
endmodule // cnc_user_model

//--- sim/cnc_clock_network_control_test.sv
// Purpose: Testbench for the clock network control block
// Assumes: Reset held two cycles
// Notes: APB results checked through a queue
`timescale 1ns/1ps
module cnc_clock_network_control_test;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, um = 0, quiet = 0, ena_req = 0;
  logic [11:0] paddr = 12'h0, clk_pin = 12'h0;
  logic [11:0] logic_array_block;
  logic [31:0] pwdata = 32'h0, prdata, rgn_ena, rcn;
  logic [15:0] sel_req = 16'h0, dyn_sel, glb_ena, gcn;
  logic [7:0] loop_out = 8'h0;
  logic [3:0] core_clk, lpo_ena, lpo_int, lpin, col, row;
  logic [1:0] xcvr = 2'h0;
  logic pready, pslverr;
  logic [32:0] exp_q[$];
  int num_errors = 0, n_checks = 0;
  always #50 clock = ~clock;
  cnc_clock_network_control DUT (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .USER_MODE(um), .CLK_PIN(clk_pin), .LOOP_OUT(loop_out),
    .CORE_CLK(core_clk), .XCVR_CLK(xcvr), .DYN_SEL(dyn_sel), .GLB_ENA(glb_ena),
    .RGN_ENA(rgn_ena), .LPO_ENA(lpo_ena), .LPO_INT(lpo_int), .GLOBAL_CLOCK_NET(gcn),
    .REGIONAL_CLOCK_NET(rcn), .LOOP_PIN(lpin), .LAB_CLOCK(logic_array_block), .COL_IOE_CLOCK(col),
    .ROW_IOE_CLOCK(row));
  cnc_user_model u_user (.clock(clock), .sel_req(sel_req), .ena_req(ena_req),
    .dyn_sel(dyn_sel), .glb_ena(glb_ena), .rgn_ena(rgn_ena), .lpo_ena(lpo_ena),
    .core_clk(core_clk), .lpo_int(lpo_int));
  // ****
  // Sources and monitor
  // ****
  always @(posedge clock) begin
    clk_pin <= quiet ? 12'h000 : 12'($urandom);
    loop_out <= quiet ? 8'h00 : 8'($urandom);
    xcvr <= 2'($urandom);
    if (pready === 1'b1) check({pslverr, prdata}, exp_q.pop_front());
  end
  task check(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    exp_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      num_errors++;
      complete_run();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  // ****
  // Clock path run
  // ****
  task run(input logic s, input logic e);
    logic [7:0] p;
    logic g;
    sel_req <= {14'h0, s, 1'b0};
    ena_req <= e;
    quiet <= 1;
    repeat (4) @(posedge clock);
    quiet <= 0;
    @(negedge clock);
    repeat (20) begin
      p = {lpo_int, e & clk_pin[8], 1'b0, e & (um ? loop_out[s] : clk_pin[0]), e & clk_pin[8]};
      g = gcn[0];
      @(negedge clock);
      check({25'h0, lpin, rcn[1:0], gcn[1:0]}, {25'h0, p});
      check({30'h0, logic_array_block[0], col[0], row[0]}, {30'h0, {3{g}}});
    end
    @(posedge clock);
  endtask
  initial begin
    void'($urandom(32'h3BCF6F04));
    repeat (2) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    apb(0, 12'h000, 32'h0, 33'h0);
    apb(0, 12'h100, 32'h0, 33'h0);
    apb(1, 12'h000, 32'h00010008, 33'h0);
    apb(1, 12'h004, 32'h00016B20, 33'h0);
    apb(1, 12'h040, 32'h00010000, 33'h0);
    apb(1, 12'h044, 32'h00010008, 33'h0);
    apb(0, 12'h004, 32'h0, 33'h000016B20);
    run(1'b0, 1'b1);
    um <= 1;
    run(1'b0, 1'b1);
    run(1'b1, 1'b1);
    run(1'b1, 1'b0);
    apb(1, 12'h000, 32'h0, 33'h100000000);
    apb(1, 12'h100, 32'h0, 33'h100000000);
    apb(0, 12'h200, 32'h0, 33'h100000000);
    apb(0, 12'h000, 32'h0, 33'h000010008);
    complete_run();
  end
endmodule // cnc_clock_network_control_test
